// >>> rtl/dps_slave.sv
// Two-wire serial slave interface of the digital potentiometer
//
// Notes on behaviour
// (R1) Slave only: SCL is never driven, master makes clock and bus access.
// (R2) Master sends the address byte first after every start.
// (R3) SDA is captured on each rising SCL edge while it is an input.
// (R4) SDA change while SCL high is a start or stop, never data.
// (R5) SDA changes only while SCL low, except for start and stop.
// (R6) Standard, fast and highest rate clock modes up to 3.4 MHz.
// (R7) No clock stretching; read data is ready at once.
// (R8) Lowest strap is captured once after reset release and then held.
// (R9) Middle and upper straps should be tied static by the board.
// (R10) High-voltage input flags the current command sequence.
// (R11) Only 7-bit addresses; ten-bit frames are never acknowledged.
// (R12) Valid address is acknowledged by SDA low on the ninth clock.
// (R13) Non-matching address leaves SDA high on the ninth clock.
// (R14) Broadcast call acknowledged only when its enable is set.
// (R15) Invalid location and operation code pair is not acknowledged.
// (R16) After an error a new start resets the command state machine.
// (R17) Falling SDA while SCL high is a start that begins a transfer.
// (R18) Repeated start continues the transaction without a stop.
// (R19) Stop returns the interface to idle.
// (R20) Address is fixed 0101 followed by the three strap levels.
// (R21) SDA is released except for acknowledges and read data bits.
//
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/1ps
module dps_slave
#(
	parameter int DATA_W = 9
)
(
	input  wire logic              core_clk_in,
	input  wire logic              rst_in,
	input  wire logic              scl_in,
	input  wire logic              sda_in,
	input  wire logic              lowest_address_strap_in,
	input  wire logic              middle_address_strap_in,
	input  wire logic              upper_address_strap_in,
	input  wire logic              high_voltage_command_input_in,
	input  wire logic              broadcast_call_accept_enable_in,
	input  wire logic [DATA_W-1:0] read_data_in,
	output logic                   sda_out,
	output logic                   sda_oe_n_out,
	output logic                   scl_out,
	output logic                   scl_oe_n_out,
	output logic                   addressed_out,
	output logic                   broadcast_out,
	output logic                   high_voltage_cmd_out,
	output logic [3:0]             memory_location_field_out,
	output logic [1:0]             operation_code_field_out,
	output logic                   cmd_valid_out,
	output logic [DATA_W-1:0]      write_data_out,
	output logic                   write_strobe_out
);

	////////////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed
	{
		dps_pkg::dps_state_type state;
		logic [3:0]             bit_cnt;
		logic [7:0]             shift;
		logic                   ack_phase;
		logic                   drive_low;
		logic                   rd;
		logic                   bcast;
		logic                   hv;
		logic [1:0]             data_idx;
		logic [DATA_W-1:0]      tx;
		logic [1:0]             lsa_meta;
		logic [1:0]             msa_meta;
		logic [1:0]             usa_meta;
		logic [1:0]             hv_meta;
		dps_pkg::dps_strap_type strap;
		logic [1:0]             strap_wait;
		logic [3:0]             loc;
		logic [1:0]             op;
		logic                   cmd_valid;
		logic [DATA_W-1:0]      wdata;
		logic                   wstrobe;
	} dps_slave_state_type;

	dps_slave_state_type   s_r;
	dps_slave_state_type   s_nxt;
	dps_pkg::dps_line_type line;

	dps_line_sync u_sync
	(
		.core_clk_in (core_clk_in),
		.rst_in      (rst_in),
		.scl_in      (scl_in), // (R6)
		.sda_in      (sda_in),
		.line_out    (line)
	);

	////////////////////////////////////////////////////////////////////////////
	// Decoding

	function automatic logic combo_ok(input logic [3:0] loc, input logic [1:0] op);
		combo_ok = dps_pkg::LOC_VALID_MASK[loc] &
			((op == dps_pkg::OP_WRITE) | (op == dps_pkg::OP_READ) | (loc < 4'h2));
	endfunction : combo_ok

	logic [6:0] own_addr;
	logic [7:0] byte_in;

	always_comb
	begin
		own_addr = {dps_pkg::FIXED_ADDR_HI, s_r.strap.strap}; // (R20)
		byte_in  = {s_r.shift[6:0], line.sda};
	end

	////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb
	begin
		s_nxt          = s_r;
		s_nxt.wstrobe  = 1'b0;
		s_nxt.lsa_meta = {s_r.lsa_meta[0], lowest_address_strap_in};
		s_nxt.msa_meta = {s_r.msa_meta[0], middle_address_strap_in};
		s_nxt.usa_meta = {s_r.usa_meta[0], upper_address_strap_in};
		s_nxt.hv_meta  = {s_r.hv_meta[0], high_voltage_command_input_in};
		// Upper straps follow their static pins; lowest is frozen after reset
		s_nxt.strap.strap[2:1] = {s_r.usa_meta[1], s_r.msa_meta[1]}; // (R9)
		// Wait until the strap synchroniser holds the pin level, not its reset value
		if (!s_r.strap.strap_taken)
		begin
			if (s_r.strap_wait == 2'h2)
			begin
				s_nxt.strap.strap[0]    = s_r.lsa_meta[1]; // (R8)
				s_nxt.strap.strap_taken = 1'b1;
			end
			else
			begin
				s_nxt.strap_wait = s_r.strap_wait + 2'h1;
			end
		end
		if (s_r.state != dps_pkg::ST_IDLE && s_r.hv_meta[1])
		begin
			s_nxt.hv = 1'b1; // (R10)
		end

		if (line.start)
		begin
			// Start or repeated start: command machine restarts on the address
			s_nxt.state     = dps_pkg::ST_ADDR; // (R16) (R17) (R18)
			s_nxt.bit_cnt   = 4'h0;
			s_nxt.ack_phase = 1'b0;
			s_nxt.drive_low = 1'b0;
			s_nxt.bcast     = 1'b0;
			s_nxt.hv        = s_r.hv_meta[1];
		end
		else if (line.stop)
		begin
			s_nxt.state     = dps_pkg::ST_IDLE; // (R19)
			s_nxt.drive_low = 1'b0;
			s_nxt.ack_phase = 1'b0;
			s_nxt.hv        = 1'b0;
		end
		else if (s_r.state != dps_pkg::ST_IDLE && s_r.state != dps_pkg::ST_IGN)
		begin
			if (line.scl_rise)
			begin
				if (s_r.ack_phase)
				begin
					// Master not-acknowledge ends a read
					if (s_r.state == dps_pkg::ST_SEND && line.sda)
					begin
						s_nxt.state = dps_pkg::ST_IGN;
					end
				end
				else
				begin
					s_nxt.shift   = byte_in; // (R3)
					s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
				end
			end
			else if (line.scl_fall)
			begin
				// Outputs set on this edge change only while SCL is low
				s_nxt.drive_low = 1'b0; // (R5) (R21)
				if (s_r.ack_phase)
				begin
					s_nxt.ack_phase = 1'b0;
					s_nxt.bit_cnt   = 4'h0;
					if (s_r.state == dps_pkg::ST_SEND)
					begin
						s_nxt.drive_low = ~s_r.tx[7]; // (R21)
						s_nxt.tx        = {s_r.tx[DATA_W-2:0], 1'b1};
					end
				end
				else if (s_r.bit_cnt == 4'h8)
				begin
					s_nxt.ack_phase = 1'b1;
					case (s_r.state)
						dps_pkg::ST_ADDR:
						begin
							s_nxt.rd = s_r.shift[0];
							if (s_r.shift[7:3] == dps_pkg::TEN_BIT_PREFIX)
							begin
								s_nxt.state = dps_pkg::ST_IGN; // (R11)
							end
							else if (s_r.shift[7:1] == own_addr)
							begin
								s_nxt.drive_low = 1'b1; // (R12)
								s_nxt.state     = dps_pkg::ST_CMD;
								s_nxt.data_idx  = 2'h0;
								if (s_r.shift[0])
								begin
									s_nxt.state    = dps_pkg::ST_SEND;
									s_nxt.tx       = read_data_in; // (R7)
								end
							end
							else if (s_r.shift[7:1] == dps_pkg::BCAST_ADDR && !s_r.shift[0]
								&& broadcast_call_accept_enable_in)
							begin
								s_nxt.drive_low = 1'b1; // (R14)
								s_nxt.bcast     = 1'b1;
								s_nxt.state     = dps_pkg::ST_CMD;
							end
							else
							begin
								s_nxt.state = dps_pkg::ST_IGN; // (R13)
							end
						end
						dps_pkg::ST_CMD:
						begin
							s_nxt.loc       = s_r.shift[7:4];
							s_nxt.op        = s_r.shift[3:2];
							s_nxt.cmd_valid = combo_ok(s_r.shift[7:4], s_r.shift[3:2]);
							if (combo_ok(s_r.shift[7:4], s_r.shift[3:2]))
							begin
								s_nxt.drive_low = 1'b1;
								s_nxt.wdata     = {{(DATA_W-1){1'b0}}, s_r.shift[0]};
								s_nxt.state     = (s_r.shift[3:2] == dps_pkg::OP_WRITE) ?
									dps_pkg::ST_DATA : dps_pkg::ST_CMD;
								s_nxt.wstrobe   = (s_r.shift[3:2] != dps_pkg::OP_WRITE);
							end
							else
							begin
								s_nxt.state = dps_pkg::ST_IGN; // (R15)
							end
						end
						dps_pkg::ST_DATA:
						begin
							s_nxt.drive_low = 1'b1;
							s_nxt.wdata     = {s_r.wdata[0], s_r.shift};
							s_nxt.wstrobe   = 1'b1;
							s_nxt.state     = dps_pkg::ST_CMD;
						end
						dps_pkg::ST_SEND:
						begin
							s_nxt.drive_low = 1'b0;
						end
						default:
						begin
							s_nxt.state = dps_pkg::ST_IGN;
						end
					endcase
				end
				else if (s_r.state == dps_pkg::ST_SEND)
				begin
					s_nxt.drive_low = ~s_r.tx[7]; // (R21)
					s_nxt.tx        = {s_r.tx[DATA_W-2:0], 1'b1};
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			s_r <= '0;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	always_comb
	begin
		sda_out                   = 1'b0;
		sda_oe_n_out              = ~s_r.drive_low;
		scl_out                   = 1'b0;
		scl_oe_n_out              = 1'b1; // (R1) (R7)
		addressed_out             = (s_r.state != dps_pkg::ST_IDLE) && (s_r.state != dps_pkg::ST_IGN)
			&& (s_r.state != dps_pkg::ST_ADDR);
		broadcast_out             = s_r.bcast;
		high_voltage_cmd_out      = s_r.hv;
		memory_location_field_out = s_r.loc;
		operation_code_field_out  = s_r.op;
		cmd_valid_out             = s_r.cmd_valid;
		write_data_out            = s_r.wdata;
		write_strobe_out          = s_r.wstrobe;
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks

	scl_never_low_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
		scl_oe_n_out) else $error("SCL driven"); // (R1)

	stop_idles_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
		line.stop |=> s_r.state == dps_pkg::ST_IDLE && sda_oe_n_out) else $error("stop not idle"); // (R19)

	start_addr_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
		line.start |=> s_r.state == dps_pkg::ST_ADDR && s_r.bit_cnt == 4'h0) else $error("start lost"); // (R17)

	sda_hold_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
		line.scl && !line.scl_rise && !line.start |=> $stable(sda_oe_n_out) || $past(line.stop))
		else $error("SDA moved high"); // (R5)

	nack_miss_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
		line.scl_fall && s_r.state == dps_pkg::ST_ADDR && s_r.bit_cnt == 4'h8
		&& s_r.shift[7:1] != own_addr && s_r.shift[7:1] != dps_pkg::BCAST_ADDR
		|=> sda_oe_n_out) else $error("ack on miss"); // (R13)

	ack_hit_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
		line.scl_fall && s_r.state == dps_pkg::ST_ADDR && s_r.bit_cnt == 4'h8
		&& s_r.shift[7:1] == own_addr && !line.start && !line.stop |=> !sda_oe_n_out) else $error("no ack"); // (R12)

	bcast_gate_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
		s_r.bcast |-> $past(broadcast_call_accept_enable_in, 1) || $past(s_r.bcast)) else $error("bcast ack"); // (R14)

	strap_hold_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
		s_r.strap.strap_taken && $past(s_r.strap.strap_taken) |-> $stable(s_r.strap.strap[0]))
		else $error("strap moved"); // (R8)

endmodule : dps_slave

// >>> rtl/dps_pkg.sv
// Package for the two-wire slave interface of the digital potentiometer
package dps_pkg;

	// Fixed upper address bits of the 7-bit slave address
	localparam logic [3:0] FIXED_ADDR_HI   = 4'h5;
	localparam logic [6:0] BCAST_ADDR      = 7'h00;
	// Ten-bit address prefix 11110xx
	localparam logic [4:0] TEN_BIT_PREFIX  = 5'h1e;
	localparam logic [3:0] BIT_COUNT_LAST  = 4'h7;
	localparam logic [1:0] PIN_SYNC_RESET  = 2'h3;
	// Memory locations that exist in the command map
	localparam logic [15:0] LOC_VALID_MASK = 16'h003f;
	localparam logic [1:0] OP_WRITE        = 2'h0;
	localparam logic [1:0] OP_INC          = 2'h1;
	localparam logic [1:0] OP_DEC          = 2'h2;
	localparam logic [1:0] OP_READ         = 2'h3;

	typedef enum logic [2:0]
	{
		ST_IDLE  = 3'b000,
		ST_ADDR  = 3'b001,
		ST_CMD   = 3'b010,
		ST_DATA  = 3'b011,
		ST_SEND  = 3'b100,
		ST_IGN   = 3'b101
	} dps_state_type;

	// Synchronised line levels and edge events
	typedef struct packed
	{
		logic scl;
		logic sda;
		logic scl_rise;
		logic scl_fall;
		logic start;
		logic stop;
	} dps_line_type;

	typedef struct packed
	{
		logic [2:0] strap;
		logic       strap_taken;
	} dps_strap_type;

endpackage : dps_pkg

// >>> rtl/dps_line_sync.sv
// Two-flop synchroniser and bus condition detector for the serial lines
`timescale 1ns/1ps
module dps_line_sync
(
	input  wire logic              core_clk_in,
	input  wire logic              rst_in,
	input  wire logic              scl_in,
	input  wire logic              sda_in,
	output dps_pkg::dps_line_type  line_out
);

	typedef struct packed
	{
		logic [1:0] scl_meta;
		logic [1:0] sda_meta;
		logic       scl_old;
		logic       sda_old;
		dps_pkg::dps_line_type line;
	} dps_sync_state_type;

	dps_sync_state_type s_r;
	dps_sync_state_type s_nxt;

	always_comb
	begin
		s_nxt          = s_r;
		s_nxt.scl_meta = {s_r.scl_meta[0], scl_in};
		s_nxt.sda_meta = {s_r.sda_meta[0], sda_in};
		s_nxt.scl_old  = s_r.scl_meta[1];
		s_nxt.sda_old  = s_r.sda_meta[1];
		s_nxt.line.scl = s_r.scl_meta[1];
		s_nxt.line.sda = s_r.sda_meta[1];
		s_nxt.line.scl_rise = s_r.scl_meta[1] & ~s_r.scl_old;
		s_nxt.line.scl_fall = ~s_r.scl_meta[1] & s_r.scl_old;
		// SDA moving while SCL stays high is a condition, not data
		s_nxt.line.start = s_r.scl_meta[1] & s_r.scl_old & s_r.sda_old & ~s_r.sda_meta[1]; // (R4) (R17)
		s_nxt.line.stop  = s_r.scl_meta[1] & s_r.scl_old & ~s_r.sda_old & s_r.sda_meta[1]; // (R4) (R19)
	end

	always_ff @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			s_r <= '{scl_meta: dps_pkg::PIN_SYNC_RESET, sda_meta: dps_pkg::PIN_SYNC_RESET,
				scl_old: 1'b1, sda_old: 1'b1,
				line: '{scl: 1'b1, sda: 1'b1, scl_rise: 1'b0, scl_fall: 1'b0, start: 1'b0, stop: 1'b0}};
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	assign line_out = s_r.line;

endmodule : dps_line_sync

// >>> tb/dps_master.sv
// Bus master model that drives the serial clock and data lines
`timescale 1ns/1ps
module dps_master
(
	input  wire logic core_clk_in,
	input  wire logic sda_in,
	output logic      scl_out,
	output logic      sda_out
);

	// Both lines start released, so the pull-up shows the idle level
	initial
	begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk_in);
	endtask : tick

	// Start, or repeated start after a data or acknowledge bit
	task automatic start_c();
		sda_out <= 1'b1;
		tick(3);
		scl_out <= 1'b1;
		tick(3);
		sda_out <= 1'b0;
		tick(3);
		scl_out <= 1'b0;
		tick(3);
	endtask : start_c

	task automatic stop_c();
		sda_out <= 1'b0;
		tick(3);
		scl_out <= 1'b1;
		tick(3);
		sda_out <= 1'b1;
		tick(6);
	endtask : stop_c

	// Data moves only while the clock is low; a bit takes 12 cycles
	task automatic bit_c(input logic b, output logic s);
		sda_out <= b;
		tick(3);
		scl_out <= 1'b1;
		tick(3);
		s = sda_in;
		tick(3);
		scl_out <= 1'b0;
		tick(3);
	endtask : bit_c

	// Eight bits MSB first, then the acknowledge clock
	task automatic byte_c(input logic [7:0] d, input logic mack, output logic [7:0] q, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
		begin
			bit_c(d[i], s);
			q[i] = s;
		end
		bit_c(mack, ack);
	endtask : byte_c

endmodule : dps_master

// >>> tb/tb_dps_slave.sv
// Testbench of the two-wire slave interface
`timescale 1ns/1ps
module tb_dps_slave;

	logic       core_clk_in;
	logic       rst_in;
	logic       lowest_address_strap_in;
	logic       middle_address_strap_in;
	logic       upper_address_strap_in;
	logic       high_voltage_command_input_in;
	logic       broadcast_call_accept_enable_in;
	logic [8:0] read_data_in;
	logic       sda_out;
	logic       sda_oe_n_out;
	logic       scl_out;
	logic       scl_oe_n_out;
	logic       addressed_out;
	logic       broadcast_out;
	logic       high_voltage_cmd_out;
	logic [3:0] memory_location_field_out;
	logic [1:0] operation_code_field_out;
	logic       cmd_valid_out;
	logic [8:0] write_data_out;
	logic       write_strobe_out;
	wire        scl_in;
	wire        sda_in;
	wire        m_sda;
	int         miscompares;
	int         num_checks;
	int         n_str;
	logic [8:0] wd;
	logic       scl_drv;
	logic [7:0] q;
	logic       a;

	// Open-drain wire with pull-up
	assign sda_in = m_sda & (sda_oe_n_out | sda_out);

	dps_slave dut (.core_clk_in, .rst_in, .scl_in, .sda_in, .lowest_address_strap_in, .middle_address_strap_in,
		.upper_address_strap_in, .high_voltage_command_input_in, .broadcast_call_accept_enable_in, .read_data_in,
		.sda_out, .sda_oe_n_out, .scl_out, .scl_oe_n_out, .addressed_out, .broadcast_out, .high_voltage_cmd_out,
		.memory_location_field_out, .operation_code_field_out, .cmd_valid_out, .write_data_out, .write_strobe_out);

	dps_master m (.core_clk_in(core_clk_in), .sda_in(sda_in), .scl_out(scl_in), .sda_out(m_sda));

	////////////////////////////////////////////////////////////////
	initial
	begin
		core_clk_in = 1'b0;
		forever #5 core_clk_in = ~core_clk_in;
	end

	always @(posedge core_clk_in)
	begin
		if (write_strobe_out === 1'b1)
		begin
			n_str <= n_str + 1;
			wd <= write_data_out;
		end
		if (!rst_in && scl_oe_n_out !== 1'b1)
			scl_drv <= 1'b1;
	end

	task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
		num_checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// Write one byte and compare the level seen on the ninth clock
	task automatic wb(input logic [7:0] d, input logic e, input string nm);
		m.byte_c(d, 1'b1, q, a);
		chk(nm, {8'h00, e}, {8'h00, a});
	endtask : wb

	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : final_report

	initial
	begin
		#400000;
		miscompares++;
		final_report();
	end

	////////////////////////////////////////////////////////////////
	initial
	begin
		miscompares = 0;
		num_checks = 0;
		n_str = 0;
		wd = 9'h000;
		scl_drv = 1'b0;
		rst_in = 1'b1;
		lowest_address_strap_in = 1'b1;
		middle_address_strap_in = 1'b0;
		upper_address_strap_in = 1'b1;
		high_voltage_command_input_in = 1'b0;
		broadcast_call_accept_enable_in = 1'b0;
		read_data_in = 9'h13c;
		repeat (2) @(posedge core_clk_in);
		rst_in <= 1'b0;
		m.tick(6);
		chk("sda_oe_n", 9'h001, {8'h00, sda_oe_n_out});
		chk("addressed", 9'h000, {8'h00, addressed_out});
		// Strap changes after reset; latched level must stay in use
		lowest_address_strap_in <= 1'b0;
		high_voltage_command_input_in <= 1'b1;
		m.start_c();
		wb(8'h5b - 8'h01, 1'b0, "addr ack");
		chk("addressed", 9'h001, {8'h00, addressed_out});
		chk("hv cmd", 9'h001, {8'h00, high_voltage_cmd_out});
		wb(8'h01, 1'b0, "cmd write");
		wb(8'ha5, 1'b0, "data");
		m.stop_c();
		chk("strobes", 9'h001, n_str[8:0]);
		chk("wdata", 9'h1a5, wd);
		chk("addressed", 9'h000, {8'h00, addressed_out});
		chk("hv cmd", 9'h000, {8'h00, high_voltage_cmd_out});
		high_voltage_command_input_in <= 1'b0;
		$display("test write done");
		m.start_c();
		wb(8'h58, 1'b1, "addr mismatch");
		m.stop_c();
		m.start_c();
		wb(8'hf0, 1'b1, "ten bit");
		m.stop_c();
		m.start_c();
		wb(8'h00, 1'b1, "bcast off");
		m.stop_c();
		broadcast_call_accept_enable_in <= 1'b1;
		m.start_c();
		wb(8'h00, 1'b0, "bcast on");
		chk("broadcast", 9'h001, {8'h00, broadcast_out});
		m.stop_c();
		$display("test refuse done");
		for (int op = 1; op <= 2; op++)
		begin
			m.start_c();
			wb(8'h5a, 1'b0, "addr");
			wb({4'h0, op[1:0], 2'b00}, 1'b0, "cmd incdec");
			chk("opcode", {7'h00, op[1:0]}, {7'h00, operation_code_field_out});
			m.stop_c();
		end
		m.start_c();
		wb(8'h5a, 1'b0, "addr");
		wb(8'h24, 1'b1, "cmd invalid");
		chk("location", 9'h002, {5'h00, memory_location_field_out});
		chk("cmd valid", 9'h000, {8'h00, cmd_valid_out});
		m.start_c();
		wb(8'h5a, 1'b0, "addr restart");
		wb(8'h00, 1'b0, "cmd write");
		wb(8'h77, 1'b0, "data");
		m.stop_c();
		chk("strobes", 9'h004, n_str[8:0]);
		chk("wdata", 9'h077, wd);
		$display("test commands done");
		m.start_c();
		wb(8'h5b, 1'b0, "addr read");
		m.byte_c(8'hff, 1'b1, q, a);
		chk("read data", 9'h03c, {1'b0, q});
		m.stop_c();
		chk("sda_oe_n", 9'h001, {8'h00, sda_oe_n_out});
		chk("scl driven", 9'h000, {8'h00, scl_drv});
		$display("test read done");
		final_report();
	end

endmodule : tb_dps_slave
